// [rtl/sleep_wakeup_control_regs.svh]
// Register offsets, field positions and timing counts of the sleep and wake-up control
`ifndef SLEEP_WAKEUP_CONTROL_REGS_SVH
`define SLEEP_WAKEUP_CONTROL_REGS_SVH

// Register byte offsets
`define SWC_CTRL_OFF 12'h000
`define SWC_STAT_OFF 12'h004
`define SWC_IRQ_STAT_OFF 12'h008
`define SWC_IRQ_MASK_OFF 12'h00c
`define SWC_SRC_EN_OFF 12'h010
`define SWC_SRC_FLAG_OFF 12'h014

// Control register fields
`define SWC_CTRL_GIE 0
`define SWC_CTRL_WDT_EN 1
`define SWC_CTRL_T1_ASYNC 2
`define SWC_CTRL_ADC_RC 3

// Status register fields, matching the core status bits
`define SWC_STAT_PD 3
`define SWC_STAT_TO 4
`define SWC_STAT_ASLEEP 0

// Interrupt status fields
`define SWC_IRQ_SLEEP 0
`define SWC_IRQ_WAKE 1
`define SWC_IRQ_NOP 2

// Wake source count and bit positions
`define SWC_NSRC 11
`define SWC_SRC_INT 0
`define SWC_SRC_RBCHG 1
`define SWC_SRC_PSP 2
`define SWC_SRC_TIMER_ONE 3
`define SWC_SRC_CAPT 4
`define SWC_SRC_SPEV 5
`define SWC_SRC_SSP_SS 6
`define SWC_SRC_SSP_SL 7
`define SWC_SRC_USART 8
`define SWC_SRC_ADC 9
`define SWC_SRC_EE 10

// Interrupt vector address and oscillator restart time
`define SWC_VECTOR 13'h0004
`define SWC_OSC_START_NS 40
`define SWC_CLK_NS 4
`define SWC_OSC_CYCLES ((`SWC_OSC_START_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS)

`endif

// [rtl/sleep_wakeup_control_pkg.sv]
// Types of the sleep and wake-up control
package sleep_wakeup_control_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_OSC = 4'b0100,
    ST_RESUME = 4'b1000
  } state_e;
endpackage

// [rtl/sleep_wakeup_control.sv]
// Power-down entry and wake-up control with APB registers
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "sleep_wakeup_control_regs.svh"
// How it works
// - Halt instruction enters power-down
// - Entry clears watchdog, clears power-down, sets time-out
// - Port pins hold drive during power-down
// - Wake on reset, watchdog, or interrupt
// - Master clear resets; others continue execution
// - Power-down flag set at power-up
// - Watchdog wake with no interrupt wake in the same cycle clears time-out flag
// - Listed peripheral interrupts can wake device
// - Timer one wakes only when asynchronous
// - Converter wakes only with RC clock
// - Clocked peripherals cannot interrupt while asleep
// - Halt prefetches the next instruction
// - Individual enable gates wake; global ignored
// - Resume after halt, vector if global set
// - Pending interrupt makes halt a no-op
// - Interrupt during halt completes then wakes
module sleep_wakeup_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core instruction flow
  input wire logic halt_exec,
  input wire logic [12:0] core_pc,
  output logic core_stall,
  output logic prefetch_req,
  output logic [12:0] prefetch_addr,
  output logic vector_req,
  output logic [12:0] vector_addr,
  // Master clear pin, watchdog and clock driver
  input wire logic master_clear_pin,
  input wire logic watchdog_timeout,
  output logic watchdog_clear,
  output logic osc_enable,
  output logic device_reset,
  output logic port_hold,
  // Interrupt sources from clockless peripherals
  input wire logic [`SWC_NSRC-1:0] src_irq,
  // Interrupt to host
  output logic irq
);

  sleep_wakeup_control_pkg::state_e state;
  logic [`SWC_NSRC-1:0] src_en;
  logic [`SWC_NSRC-1:0] src_flag;
  logic global_interrupt_enable;
  logic wdt_en;
  logic t1_async;
  logic adc_rc;
  logic power_down_flag;
  logic time_out_flag;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [7:0] osc_cnt;
  logic resume_vector;
  logic [2:0] master_clear_pin_sync;
  logic [2:0] wdt_sync;
  logic [`SWC_NSRC-1:0] src_s1;
  logic [`SWC_NSRC-1:0] src_s2;
  logic [`SWC_NSRC-1:0] src_s3;
  logic master_clear_pin_low;
  logic wdt_evt;
  logic [`SWC_NSRC-1:0] src_ok;
  logic [`SWC_NSRC-1:0] src_stable;
  logic wake_irq;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [2:0] ev_set;
  // Agreement-filtered levels of the synchronised inputs
  logic master_clear_pin_level;
  logic wdt_level;
  logic [`SWC_NSRC-1:0] src_level;

  // Pins and peripherals come from outside the clock; three stages, change on agreement
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      master_clear_pin_sync <= 3'h7;
      wdt_sync <= 3'h0;
      src_s1 <= '0;
      src_s2 <= '0;
      src_s3 <= '0;
    end else begin
      master_clear_pin_sync <= {master_clear_pin_sync[1:0], master_clear_pin};
      wdt_sync <= {wdt_sync[1:0], watchdog_timeout};
      src_s1 <= src_irq;
      src_s2 <= src_s1;
      src_s3 <= src_s2;
    end
  end

  // A level changes only once stages two and three agree, so a glitch one clock
  // wide never reaches the sequencer; the price is one more clock of latency
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      master_clear_pin_level <= 1'b1;
      wdt_level <= 1'b0;
    end else begin
      if (master_clear_pin_sync[1] == master_clear_pin_sync[2]) begin
        master_clear_pin_level <= master_clear_pin_sync[2];
      end
      if (wdt_sync[1] == wdt_sync[2]) begin
        wdt_level <= wdt_sync[2];
      end
    end
  end

  // Same agreement filter for every peripheral flag
  generate
    for (genvar i = 0; i < `SWC_NSRC; i++) begin : g_filt
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          src_level[i] <= 1'b0;
        end else if (src_s2[i] == src_s3[i]) begin
          src_level[i] <= src_s3[i];
        end
      end
    end
  endgenerate

  // Filtered events as the sequencer sees them
  assign master_clear_pin_low = !master_clear_pin_level;
  assign wdt_evt = wdt_level && wdt_en;
  assign src_stable = src_level;

  // Qualify each source by its clocking condition and its enable
  generate
    for (genvar i = 0; i < `SWC_NSRC; i++) begin : g_src
      if (i == `SWC_SRC_TIMER_ONE || i == `SWC_SRC_SPEV) begin : g_t1
        assign src_ok[i] = src_flag[i] && src_en[i] && t1_async;
      end else if (i == `SWC_SRC_ADC) begin : g_adc
        assign src_ok[i] = src_flag[i] && src_en[i] && adc_rc;
      end else begin : g_other
        assign src_ok[i] = src_flag[i] && src_en[i];
      end
    end
  endgenerate

  // Global enable deliberately plays no part in the wake decision
  assign wake_irq = |src_ok;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign mapped = paddr == `SWC_CTRL_OFF || paddr == `SWC_STAT_OFF ||
                  paddr == `SWC_IRQ_STAT_OFF || paddr == `SWC_IRQ_MASK_OFF ||
                  paddr == `SWC_SRC_EN_OFF || paddr == `SWC_SRC_FLAG_OFF;

  // Source flags: hardware set wins over a write-one clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      src_flag <= '0;
    end else begin
      for (int i = 0; i < `SWC_NSRC; i++) begin
        if (src_stable[i]) begin
          src_flag[i] <= 1'b1;
        end else if (wr_en && paddr == `SWC_SRC_FLAG_OFF && pwdata[i]) begin
          src_flag[i] <= 1'b0;
        end
      end
    end
  end

  // Control and enable registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      global_interrupt_enable <= 1'b0;
      wdt_en <= 1'b0;
      t1_async <= 1'b0;
      adc_rc <= 1'b0;
      src_en <= '0;
      irq_mask <= 3'h0;
    end else if (wr_en) begin
      if (paddr == `SWC_CTRL_OFF) begin
        global_interrupt_enable <= pwdata[`SWC_CTRL_GIE];
        wdt_en <= pwdata[`SWC_CTRL_WDT_EN];
        t1_async <= pwdata[`SWC_CTRL_T1_ASYNC];
        adc_rc <= pwdata[`SWC_CTRL_ADC_RC];
      end
      if (paddr == `SWC_SRC_EN_OFF) begin
        src_en <= pwdata[`SWC_NSRC-1:0];
      end
      if (paddr == `SWC_IRQ_MASK_OFF) begin
        irq_mask <= pwdata[2:0];
      end
    end
  end

  // Sleep sequencer; master clear overrides every state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= sleep_wakeup_control_pkg::ST_RUN;
      osc_cnt <= 8'h00;
      resume_vector <= 1'b0;
      ev_set <= 3'h0;
    end else begin
      ev_set <= 3'h0;
      if (master_clear_pin_low) begin
        state <= sleep_wakeup_control_pkg::ST_RUN;
      end else begin
        unique case (state)
          sleep_wakeup_control_pkg::ST_RUN: begin
            if (halt_exec && wake_irq) begin
              ev_set[`SWC_IRQ_NOP] <= 1'b1;
            end else if (halt_exec) begin
              state <= sleep_wakeup_control_pkg::ST_SLEEP;
              ev_set[`SWC_IRQ_SLEEP] <= 1'b1;
            end
          end
          sleep_wakeup_control_pkg::ST_SLEEP: begin
            // Halt already complete, so a late interrupt wakes at once
            if (wake_irq || wdt_evt) begin
              state <= sleep_wakeup_control_pkg::ST_OSC;
              resume_vector <= wake_irq && global_interrupt_enable;
              osc_cnt <= 8'(`SWC_OSC_CYCLES);
              ev_set[`SWC_IRQ_WAKE] <= 1'b1;
            end
          end
          sleep_wakeup_control_pkg::ST_OSC: begin
            // Core stays stalled until the driver has run for its start time
            if (osc_cnt == 8'h01) begin
              state <= sleep_wakeup_control_pkg::ST_RESUME;
            end
            osc_cnt <= osc_cnt - 8'h01;
          end
          sleep_wakeup_control_pkg::ST_RESUME: begin
            state <= sleep_wakeup_control_pkg::ST_RUN;
          end
          default: begin
            state <= sleep_wakeup_control_pkg::ST_RUN;
          end
        endcase
      end
    end
  end

  // Core-facing outputs, all registered
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      core_stall <= 1'b0;
      prefetch_req <= 1'b0;
      prefetch_addr <= 13'h0000;
      vector_req <= 1'b0;
      vector_addr <= 13'h0000;
      watchdog_clear <= 1'b0;
      osc_enable <= 1'b1;
      device_reset <= 1'b1;
      port_hold <= 1'b0;
    end else begin
      device_reset <= mclk_reset_level(master_clear_pin_low);
      prefetch_req <= halt_exec && state == sleep_wakeup_control_pkg::ST_RUN;
      if (halt_exec) begin
        prefetch_addr <= core_pc + 13'h0001;
      end
      // Clear only on a real entry; a no-op halt leaves the watchdog alone
      watchdog_clear <= halt_exec && !wake_irq && wdt_en && !master_clear_pin_low &&
                        state == sleep_wakeup_control_pkg::ST_RUN;
      if (master_clear_pin_low) begin
        osc_enable <= 1'b1;
        core_stall <= 1'b0;
        port_hold <= 1'b0;
        vector_req <= 1'b0;
      end else begin
        osc_enable <= !(state == sleep_wakeup_control_pkg::ST_SLEEP &&
                        !(wake_irq || wdt_evt)) &&
                      !(state == sleep_wakeup_control_pkg::ST_RUN && halt_exec &&
                        !wake_irq);
        core_stall <= (state == sleep_wakeup_control_pkg::ST_RUN && halt_exec && !wake_irq) ||
                      state == sleep_wakeup_control_pkg::ST_SLEEP ||
                      (state == sleep_wakeup_control_pkg::ST_OSC && osc_cnt != 8'h01);
        // Pins keep their last drive; the port logic freezes on this level
        port_hold <= (state == sleep_wakeup_control_pkg::ST_RUN && halt_exec && !wake_irq) ||
                     state == sleep_wakeup_control_pkg::ST_SLEEP;
        // Vector after the instruction following the halt has run
        vector_req <= state == sleep_wakeup_control_pkg::ST_RESUME && resume_vector;
      end
      vector_addr <= `SWC_VECTOR;
    end
  end

  function automatic logic mclk_reset_level(input logic low);
    mclk_reset_level = low;
  endfunction

  // Status flags; master clear leaves them as they are so firmware can see the cause
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      power_down_flag <= 1'b1;
      time_out_flag <= 1'b1;
    end else if (!master_clear_pin_low) begin
      if (state == sleep_wakeup_control_pkg::ST_RUN && halt_exec && !wake_irq) begin
        power_down_flag <= 1'b0;
        time_out_flag <= 1'b1;
      end else if (state == sleep_wakeup_control_pkg::ST_SLEEP && wdt_evt && !wake_irq) begin
        time_out_flag <= 1'b0;
      end
    end
  end

  // Sticky event bits, write one to clear, set wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ev_set[i]) begin
          irq_stat[i] <= 1'b1;
        end else if (wr_en && paddr == `SWC_IRQ_STAT_OFF && pwdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  // One level interrupt, high while an unmasked event bit is set
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // APB: read data captured in setup, ready in access; one wait-free access phase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_en) begin
        prdata <= 32'h00000000;
        if (paddr == `SWC_CTRL_OFF) begin
          prdata[3:0] <= {adc_rc, t1_async, wdt_en, global_interrupt_enable};
        end
        if (paddr == `SWC_STAT_OFF) begin
          prdata[`SWC_STAT_PD] <= power_down_flag;
          prdata[`SWC_STAT_TO] <= time_out_flag;
          prdata[`SWC_STAT_ASLEEP] <= state == sleep_wakeup_control_pkg::ST_SLEEP;
        end
        if (paddr == `SWC_IRQ_STAT_OFF) begin
          prdata[2:0] <= irq_stat;
        end
        if (paddr == `SWC_IRQ_MASK_OFF) begin
          prdata[2:0] <= irq_mask;
        end
        if (paddr == `SWC_SRC_EN_OFF) begin
          prdata[`SWC_NSRC-1:0] <= src_en;
        end
        if (paddr == `SWC_SRC_FLAG_OFF) begin
          prdata[`SWC_NSRC-1:0] <= src_flag;
        end
      end
    end
  end

endmodule // sleep_wakeup_control

// [tb/sleep_wakeup_control_assertions.sv]
// Port checker for the sleep and wake-up control
`timescale 1ns/1ps
module sleep_wakeup_control_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Core side
  input wire logic halt_exec,
  input wire logic [12:0] core_pc,
  input wire logic core_stall,
  input wire logic prefetch_req,
  input wire logic [12:0] prefetch_addr,
  input wire logic vector_req,
  input wire logic [12:0] vector_addr,
  // Watchdog, clock driver and pins
  input wire logic watchdog_clear,
  input wire logic osc_enable,
  input wire logic device_reset,
  input wire logic port_hold
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Cycles the driver has run while the core is still held
  logic [7:0] run_cnt;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_cnt <= 8'h00;
    end else if (core_stall && osc_enable) begin
      run_cnt <= run_cnt + 8'h01;
    end else begin
      run_cnt <= 8'h00;
    end
  end
  // Driver restarted while the core is still stalled
  sequence restart_s;
    $rose(osc_enable) && core_stall && !device_reset;
  endsequence
  // Core released by the sequencer, not by master clear
  sequence release_s;
    $fell(core_stall) && osc_enable && !device_reset;
  endsequence
  // Previous cycle excluded so the resume cycle does not count as run
  a_halt_prefetch: assert property (halt_exec && !core_stall && !$past(core_stall)
    && !device_reset |=> prefetch_req && prefetch_addr == $past(core_pc) + 13'h0001)
    else $error("prefetch address wrong after halt");
  a_stall_cause: assert property ($rose(core_stall) |-> $past(halt_exec) && !osc_enable)
    else $error("stall without halt or with oscillator on");
  a_osc_first: assert property (restart_s |-> ##10 release_s)
    else $error("core released at wrong time after restart");
  a_release_count: assert property (release_s |-> run_cnt == 8'h0a)
    else $error("core released before the driver ran its start time");
  a_stall_bound: assert property (core_stall && osc_enable |-> ##[1:10] !core_stall)
    else $error("stall outlives oscillator restart");
  a_vector_fixed: assert property (vector_req |-> vector_addr == 13'h0004 && $past(core_stall, 2))
    else $error("vector request wrong");
  a_wdclr_entry: assert property (watchdog_clear |-> $rose(core_stall) && !osc_enable)
    else $error("watchdog clear outside sleep entry");
  a_ports_frozen: assert property (core_stall && !osc_enable |-> port_hold)
    else $error("ports not held while asleep");
  a_reset_runs: assert property (device_reset |=> !core_stall && osc_enable)
    else $error("master clear did not return to run");
endmodule // sleep_wakeup_control_checker

bind sleep_wakeup_control sleep_wakeup_control_checker sleep_wakeup_control_checker_inst (
  .mclk, .nrst, .halt_exec, .core_pc, .core_stall, .prefetch_req, .prefetch_addr,
  .vector_req, .vector_addr, .watchdog_clear, .osc_enable, .device_reset, .port_hold);

// [tb/core_partner.sv]
// Core and peripheral stand-in driving halts, pins and wake sources
`timescale 1ns/1ps
`include "sleep_wakeup_control_regs.svh"
module core_partner (
  // Clock
  input wire logic mclk,
  // Core and pins
  output logic halt_exec,
  output logic [12:0] core_pc,
  output logic master_clear_pin,
  output logic watchdog_timeout,
  output logic [`SWC_NSRC-1:0] src_irq
);
  // Idle levels; clear pin parked high so sleep is not cut short
  initial begin
    halt_exec = 1'b0;
    core_pc = 13'h0000;
    master_clear_pin = 1'b1;
    watchdog_timeout = 1'b0;
    src_irq = '0;
  end
  // One-cycle halt with its pc
  task automatic halt(input logic [12:0] pc);
    halt_exec <= 1'b1;
    core_pc <= pc;
    @(posedge mclk);
    halt_exec <= 1'b0;
  endtask
  // Flag held four cycles so the three-flop sync sees it
  task automatic pulse(input int b);
    if (b == `SWC_NSRC) watchdog_timeout <= 1'b1;
    else src_irq[b] <= 1'b1;
    repeat (4) @(posedge mclk);
    watchdog_timeout <= 1'b0;
    src_irq <= '0;
  endtask
  // Master clear level
  task automatic pin(input logic v);
    master_clear_pin <= v;
  endtask
endmodule // core_partner

// [tb/sleep_wakeup_control_bench.sv]
// Self-checking bench for the sleep and wake-up control
`timescale 1ns/1ps
`include "sleep_wakeup_control_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sleep_wakeup_control_bench;
  logic mclk = 1'b0;
  logic nrst, psel, penable, pwrite, pready, pslverr, halt_exec, core_stall, prefetch_req;
  logic vector_req, master_clear_pin, watchdog_timeout, watchdog_clear, osc_enable;
  logic device_reset, port_hold, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [12:0] core_pc, prefetch_addr, vector_addr, pc;
  logic [`SWC_NSRC-1:0] src_irq;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 46282;
  int vec_seen, g, pd, to;
  int gate[4] = '{0, 3, 5, 9};
  sleep_wakeup_control sleep_wakeup_control_inst (.mclk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .halt_exec, .core_pc, .core_stall,
    .prefetch_req, .prefetch_addr, .vector_req, .vector_addr, .master_clear_pin,
    .watchdog_timeout, .watchdog_clear, .osc_enable, .device_reset, .port_hold, .src_irq, .irq);
  core_partner core_partner_inst (.mclk, .halt_exec, .core_pc, .master_clear_pin,
    .watchdog_timeout, .src_irq);
  always #2 mclk = ~mclk;
  // Vector pulses, counted since the bench last zeroed them
  always @(posedge mclk) if (vector_req === 1'b1) vec_seen++;
  // Expected status word from the flag model
  function automatic logic [31:0] stat(input int asl);
    return 32'(to * 16 + pd * 8 + asl);
  endfunction
  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      num_errors++;
      results();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Bounded wait for the stall level
  task automatic wait_stall(input logic v);
    int n;
    n = 0;
    while (core_stall !== v && n < 60) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 60) begin
      num_errors++;
      results();
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    results();
  end
  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'($random(seed));
    nrst = 1'b0;
    pd = 1;
    to = 1;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    apb(1'b0, `SWC_STAT_OFF, 32'h0);
    `CHK(rdata, stat(0))
    apb(1'b0, 12'h020, 32'h0);
    `CHK(err, 1'b1)
    // Flag pending before the halt turns it into a no-op
    apb(1'b1, `SWC_SRC_EN_OFF, 32'h1);
    core_partner_inst.pulse(0);
    repeat (4) @(posedge mclk);
    core_partner_inst.halt(13'h0010);
    repeat (4) @(posedge mclk);
    `CHK(core_stall, 1'b0)
    apb(1'b0, `SWC_STAT_OFF, 32'h0);
    `CHK(rdata, stat(0))
    apb(1'b1, `SWC_SRC_FLAG_OFF, 32'h7ff);
    $display("no-op halt done");
    // Every source wakes when enabled and qualified; vector only with gie
    for (int i = 0; i < `SWC_NSRC; i++) begin
      g = $random(seed) & 1;
      pc = 13'($random(seed));
      apb(1'b1, `SWC_CTRL_OFF, 32'he | 32'(g));
      apb(1'b1, `SWC_SRC_EN_OFF, 32'h1 << i);
      apb(1'b1, `SWC_IRQ_MASK_OFF, 32'(i % 2 * 2));
      core_partner_inst.halt(pc);
      wait_stall(1'b1);
      `CHK(prefetch_addr, pc + 13'h0001)
      pd = 0;
      to = 1;
      apb(1'b0, `SWC_STAT_OFF, 32'h0);
      `CHK(rdata, stat(1))
      vec_seen = 0;
      core_partner_inst.pulse(i);
      wait_stall(1'b0);
      repeat (3) @(posedge mclk);
      `CHK(vec_seen, g)
      `CHK(irq, 1'(i % 2))
      apb(1'b0, `SWC_STAT_OFF, 32'h0);
      `CHK(rdata, stat(0))
      apb(1'b1, `SWC_IRQ_STAT_OFF, 32'h7);
      apb(1'b1, `SWC_SRC_FLAG_OFF, 32'h7ff);
      `CHK(irq, 1'b0)
    end
    $display("source wake done");
    // Unqualified or disabled sources stay asleep; watchdog then wakes
    foreach (gate[k]) begin
      apb(1'b1, `SWC_CTRL_OFF, 32'h2);
      apb(1'b1, `SWC_SRC_EN_OFF, gate[k] == 0 ? 32'h0 : 32'h1 << gate[k]);
      core_partner_inst.halt(13'h0040);
      wait_stall(1'b1);
      core_partner_inst.pulse(gate[k]);
      repeat (20) @(posedge mclk);
      `CHK(core_stall, 1'b1)
      core_partner_inst.pulse(`SWC_NSRC);
      wait_stall(1'b0);
      pd = 0;
      to = 0;
      apb(1'b0, `SWC_STAT_OFF, 32'h0);
      `CHK(rdata, stat(0))
      apb(1'b1, `SWC_SRC_FLAG_OFF, 32'h7ff);
    end
    $display("gated wake done");
    // Master clear while asleep resets and leaves flags alone
    core_partner_inst.halt(13'h0080);
    wait_stall(1'b1);
    to = 1;
    core_partner_inst.pin(1'b0);
    repeat (6) @(posedge mclk);
    `CHK({device_reset, core_stall, osc_enable}, 3'b101)
    core_partner_inst.pin(1'b1);
    repeat (6) @(posedge mclk);
    `CHK(device_reset, 1'b0)
    apb(1'b0, `SWC_STAT_OFF, 32'h0);
    `CHK(rdata, stat(0))
    $display("master clear done");
    // Reset in mid-sleep brings the block up as at power-up
    core_partner_inst.halt(13'h0100);
    wait_stall(1'b1);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    `CHK({core_stall, osc_enable, port_hold, device_reset}, 4'b0101)
    pd = 1;
    to = 1;
    apb(1'b0, `SWC_STAT_OFF, 32'h0);
    `CHK(rdata, stat(0))
    $display("mid-run reset done");
    results();
  end
endmodule // sleep_wakeup_control_bench
